// file: inc/hrs_consts.svh
`ifndef HRS_CONSTS_SVH
`define HRS_CONSTS_SVH

`define HRS_DEPTH      16
`define HRS_PTR_W      4
`define HRS_DATA_W     16
`define HRS_PTR_RESET  4'h0
`define HRS_PTR_TOP    4'hF
`define HRS_PTR_STEP   4'h1
`define HRS_WORD_RESET 16'h0000
`define HRS_FLAG_RESET 1'h1

`endif

// file: inc/hrs_pkg.sv
`include "hrs_consts.svh"

package hrs_pkg;
    typedef logic [`HRS_PTR_W-1:0]  hrs_ptr_t;
    typedef logic [`HRS_DATA_W-1:0] hrs_word_t;
    typedef enum logic [1:0] {
        HRS_AV_FRESH,
        HRS_AV_UNDER,
        HRS_AV_LOCKED
    } hrs_av_t;
endpackage : hrs_pkg

// file: hw/hrs_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "hrs_consts.svh"

module hrs_mem (
    input  wire logic               ref_clk,
    input  wire logic               wr_en,
    input  wire hrs_pkg::hrs_ptr_t  wr_idx,
    input  wire hrs_pkg::hrs_word_t wr_data,
    input  wire hrs_pkg::hrs_ptr_t  rd_idx,
    output hrs_pkg::hrs_word_t      rd_data
);

    // ****************************************
    // Entry storage
    // ****************************************
    // No reset on the entries: contents after reset are undefined, as in the core.
    hrs_pkg::hrs_word_t entry_r [`HRS_DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < `HRS_DEPTH; gi++) begin : g_entry
            always_ff @(posedge ref_clk) begin
                if (wr_en && (wr_idx == hrs_pkg::hrs_ptr_t'(gi))) begin
                    entry_r[gi] <= wr_data;
                end
            end
        end
    endgenerate

    assign rd_data = entry_r[rd_idx];

endmodule : hrs_mem

`default_nettype wire

// file: hw/hrs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hrs_consts.svh"

// How it works
// - Sixteen hidden entries, sixteen bits each.
// - Call or interrupt vector pushes program counter.
// - Any return kind pops top into counter.
// - High-byte latch untouched by push or pop.
// - Circular pointer, zero after every reset.
// - Reset sets the stack space flag.
// - Pointer at fifteen clears the flag.
// - Wrap fifteen to zero locks flag clear.
// - Early pop wraps to fifteen, flag clear.
// - Push after underflow pop locks flag.
// - Seventeenth push overwrites the oldest entry.

module hrs_top (
    input  wire logic               ref_clk,
    input  wire logic               rst_b,
    input  wire logic               call_push,
    input  wire logic               irq_push,
    input  wire logic               ret_pop,
    input  wire logic               return_with_literal,
    input  wire logic               return_from_interrupt,
    input  wire hrs_pkg::hrs_word_t pc_in,
    output hrs_pkg::hrs_word_t      pc_ret,
    output logic                    pc_ret_vld,
    output logic                    stack_space_flag,
    output hrs_pkg::hrs_ptr_t       depth_dbg
);

    // ****************************************
    // Reset release
    // ****************************************
    logic rst_s1_r;
    logic rst_s2_r;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    wire logic rst_sync_b = rst_s2_r;

    // ****************************************
    // Request decode
    // ****************************************
    // A simultaneous push and pop cannot come from one instruction; pop is given priority.
    wire logic do_pop  = ret_pop | return_with_literal | return_from_interrupt;
    wire logic do_push = (call_push | irq_push) & ~do_pop;

    // ****************************************
    // Pointer
    // ****************************************
    hrs_pkg::hrs_ptr_t ptr_r;
    hrs_pkg::hrs_ptr_t ptr_nxt;
    hrs_pkg::hrs_ptr_t rd_idx;
    hrs_pkg::hrs_word_t rd_data;

    always_comb begin
        ptr_nxt = ptr_r;
        if (do_push) begin
            ptr_nxt = ptr_r + `HRS_PTR_STEP;
        end else if (do_pop) begin
            ptr_nxt = ptr_r - `HRS_PTR_STEP;
        end
    end

    assign rd_idx = ptr_r - `HRS_PTR_STEP;

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ptr_r <= `HRS_PTR_RESET;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    // The entries hold only return addresses; the high-byte latch lives in the core.
    hrs_mem u_mem (
        .ref_clk (ref_clk),
        .wr_en   (do_push),
        .wr_idx  (ptr_r),
        .wr_data (pc_in),
        .rd_idx  (rd_idx),
        .rd_data (rd_data)
    );

    // ****************************************
    // Return data
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pc_ret     <= `HRS_WORD_RESET;
            pc_ret_vld <= 1'b0;
        end else begin
            pc_ret_vld <= do_pop;
            if (do_pop) begin
                pc_ret <= rd_data;
            end
        end
    end

    // ****************************************
    // Space flag
    // ****************************************
    hrs_pkg::hrs_av_t av_r;
    hrs_pkg::hrs_av_t av_nxt;

    always_comb begin
        av_nxt = av_r;
        case (av_r)
            hrs_pkg::HRS_AV_FRESH: begin
                if (do_push && ptr_r == `HRS_PTR_TOP) begin
                    av_nxt = hrs_pkg::HRS_AV_LOCKED;
                end else if (do_pop && ptr_r == `HRS_PTR_RESET) begin
                    av_nxt = hrs_pkg::HRS_AV_UNDER;
                end
            end
            hrs_pkg::HRS_AV_UNDER: begin
                // A pop in between cancels the pending lock, so the flag follows the pointer again.
                if (do_push) begin
                    av_nxt = hrs_pkg::HRS_AV_LOCKED;
                end else if (do_pop) begin
                    av_nxt = hrs_pkg::HRS_AV_FRESH;
                end
            end
            hrs_pkg::HRS_AV_LOCKED: begin
                av_nxt = hrs_pkg::HRS_AV_LOCKED;
            end
            default: begin
                av_nxt = hrs_pkg::HRS_AV_LOCKED;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            av_r <= hrs_pkg::HRS_AV_FRESH;
        end else begin
            av_r <= av_nxt;
        end
    end

    // Flag follows the next state so it reads correctly the cycle after each operation.
    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            stack_space_flag <= `HRS_FLAG_RESET;
        end else begin
            stack_space_flag <= (av_nxt == hrs_pkg::HRS_AV_FRESH)
                                && (ptr_nxt != `HRS_PTR_TOP);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            depth_dbg <= `HRS_PTR_RESET;
        end else begin
            depth_dbg <= ptr_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_FLAG_TOP: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        (depth_dbg == `HRS_PTR_TOP) |-> !stack_space_flag)
        else $error("Flag set while pointer at top.");

    AST_LOCK_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        (av_r == hrs_pkg::HRS_AV_LOCKED) |=> (!stack_space_flag) [*4])
        else $error("Flag reappeared after lock.");

    AST_WRAP_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        (do_push && ptr_r == `HRS_PTR_TOP) |=> (av_r == hrs_pkg::HRS_AV_LOCKED))
        else $error("Wrap did not lock flag.");

    AST_UNDER: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        (do_pop && ptr_r == `HRS_PTR_RESET && av_r == hrs_pkg::HRS_AV_FRESH)
        |=> (depth_dbg == `HRS_PTR_TOP) && !stack_space_flag)
        else $error("Underflow not flagged.");

    AST_UNDER_PUSH: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        (av_r == hrs_pkg::HRS_AV_UNDER && do_push) |=> (av_r == hrs_pkg::HRS_AV_LOCKED))
        else $error("Push after underflow did not lock.");

    AST_UNDER_POP: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        (av_r == hrs_pkg::HRS_AV_UNDER && do_pop) |=> stack_space_flag)
        else $error("Pop after underflow kept flag clear.");

    AST_PUSH_PTR: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        do_push |=> (ptr_r == $past(ptr_r) + `HRS_PTR_STEP))
        else $error("Push did not advance pointer.");

    AST_ROUND_TRIP: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        (do_push ##1 do_pop) |=> pc_ret_vld && (pc_ret == $past(pc_in, 2)))
        else $error("Pop did not return pushed value.");

    AST_POP_VLD: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
        do_pop |=> pc_ret_vld ##1 (pc_ret_vld == $past(do_pop)))
        else $error("Return strobe wrong.");

    AST_RESET_STATE: assert property (@(posedge ref_clk)
        $rose(rst_sync_b) |-> (ptr_r == `HRS_PTR_RESET) && stack_space_flag)
        else $error("Reset state wrong.");

    COV_WRAP: cover property (@(posedge ref_clk) disable iff (!rst_sync_b)
        do_push && ptr_r == `HRS_PTR_TOP);
    COV_UNDER: cover property (@(posedge ref_clk) disable iff (!rst_sync_b)
        av_r == hrs_pkg::HRS_AV_UNDER);
    COV_IRQ_RET: cover property (@(posedge ref_clk) disable iff (!rst_sync_b)
        irq_push ##[1:20] return_from_interrupt);
    COV_BACK_TO_BACK: cover property (@(posedge ref_clk) disable iff (!rst_sync_b)
        do_push ##1 do_pop);

endmodule : hrs_top

`default_nettype wire

// file: sim/hrs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Core decode and interrupt side: one op code becomes one request pulse.
// ********
module hrs_core_model (
    input  wire logic               ref_clk,
    input  wire logic [2:0]         op,
    input  wire hrs_pkg::hrs_word_t pc_val,
    output logic                    call_push,
    output logic                    irq_push,
    output logic                    ret_pop,
    output logic                    return_with_literal,
    output logic                    return_from_interrupt,
    output hrs_pkg::hrs_word_t      pc_in
);
    hrs_pkg::hrs_word_t last_r = 16'h0000;
    always @(posedge ref_clk) begin
        if (call_push || irq_push) begin
            last_r <= pc_val;
        end
    end
    // Outside a push the counter bus shows a changed value, so nothing stale is caught.
    always_comb begin
        call_push             = (op == 3'h1);
        irq_push              = (op == 3'h2);
        ret_pop               = (op == 3'h3);
        return_with_literal   = (op == 3'h4);
        return_from_interrupt = (op == 3'h5);
        pc_in                 = (call_push || irq_push) ? pc_val : ~last_r;
    end
endmodule : hrs_core_model
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic               ref_clk, rst_b, call_push, irq_push, ret_pop;
    logic               return_with_literal, return_from_interrupt;
    logic               pc_ret_vld, stack_space_flag;
    logic [2:0]         op;
    hrs_pkg::hrs_word_t pc_val, pc_in, pc_ret;
    hrs_pkg::hrs_ptr_t  depth_dbg;
    int                 errors, samples_checked;

    hrs_core_model partner (
        .ref_clk               (ref_clk),
        .op                    (op),
        .pc_val                (pc_val),
        .call_push             (call_push),
        .irq_push              (irq_push),
        .ret_pop               (ret_pop),
        .return_with_literal   (return_with_literal),
        .return_from_interrupt (return_from_interrupt),
        .pc_in                 (pc_in)
    );
    hrs_top uut (
        .ref_clk               (ref_clk),
        .rst_b                 (rst_b),
        .call_push             (call_push),
        .irq_push              (irq_push),
        .ret_pop               (ret_pop),
        .return_with_literal   (return_with_literal),
        .return_from_interrupt (return_from_interrupt),
        .pc_in                 (pc_in),
        .pc_ret                (pc_ret),
        .pc_ret_vld            (pc_ret_vld),
        .stack_space_flag      (stack_space_flag),
        .depth_dbg             (depth_dbg)
    );

    // ********
    // Shared tasks.
    // ********
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One request every other cycle keeps each answer apart from the next request.
    task automatic step(input logic [2:0] k, input hrs_pkg::hrs_word_t v);
        @(posedge ref_clk) op <= k;
        pc_val <= v;
        @(posedge ref_clk) op <= 3'h0;
        @(negedge ref_clk);
    endtask : step

    task automatic do_reset;
        @(posedge ref_clk) rst_b <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : do_reset

    // ********
    // Scenarios.
    // ********
    task automatic test_fill_drain;
        do_reset;
        check("depth", 16'(depth_dbg), 16'h0000);
        check("flag", 16'(stack_space_flag), 16'h0001);
        for (int i = 0; i < 15; i++) begin
            step(3'(1 + i % 2), 16'hA000 + 16'(i));
            check("depth", 16'(depth_dbg), 16'(i + 1));
            check("flag", 16'(stack_space_flag), 16'(i < 14));
        end
        for (int i = 14; i >= 0; i--) begin
            step(3'(3 + i % 3), 16'h0000);
            check("pc_ret", pc_ret, 16'hA000 + 16'(i));
            check("vld", 16'(pc_ret_vld), 16'h0001);
            check("flag", 16'(stack_space_flag), 16'h0001);
        end
        $display("test_fill_drain done");
    endtask : test_fill_drain

    task automatic test_overflow;
        do_reset;
        for (int i = 0; i < 17; i++) step(3'h1, 16'hB000 + 16'(i));
        check("depth", 16'(depth_dbg), 16'h0001);
        check("flag", 16'(stack_space_flag), 16'h0000);
        step(3'h3, 16'h0000);
        check("pc_ret", pc_ret, 16'hB010);
        for (int i = 15; i >= 1; i--) begin
            step(3'h3, 16'h0000);
            check("pc_ret", pc_ret, 16'hB000 + 16'(i));
            check("flag", 16'(stack_space_flag), 16'h0000);
        end
        $display("test_overflow done");
    endtask : test_overflow

    task automatic test_underflow;
        do_reset;
        check("depth", 16'(depth_dbg), 16'h0000);
        check("flag", 16'(stack_space_flag), 16'h0001);
        step(3'h4, 16'h0000);
        check("depth", 16'(depth_dbg), 16'h000F);
        check("flag", 16'(stack_space_flag), 16'h0000);
        step(3'h5, 16'h0000);
        check("flag", 16'(stack_space_flag), 16'h0001);
        do_reset;
        step(3'h3, 16'h0000);
        step(3'h2, 16'hC0DE);
        check("flag", 16'(stack_space_flag), 16'h0000);
        step(3'h3, 16'h0000);
        step(3'h3, 16'h0000);
        check("flag", 16'(stack_space_flag), 16'h0000);
        check("depth", 16'(depth_dbg), 16'h000E);
        $display("test_underflow done");
    endtask : test_underflow

    // Push then pop on the very next edge: the pop must see the entry just written.
    task automatic test_back_to_back;
        do_reset;
        @(posedge ref_clk) op <= 3'h2;
        pc_val <= 16'h5A5A;
        @(posedge ref_clk) op <= 3'h5;
        @(posedge ref_clk) op <= 3'h0;
        @(negedge ref_clk);
        check("pc_ret", pc_ret, 16'h5A5A);
        check("vld", 16'(pc_ret_vld), 16'h0001);
        check("depth", 16'(depth_dbg), 16'h0000);
        @(negedge ref_clk);
        check("vld", 16'(pc_ret_vld), 16'h0000);
        check("pc_ret", pc_ret, 16'h5A5A);
        $display("test_back_to_back done");
    endtask : test_back_to_back

    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // ********
    // Clock, sequence and watchdog.
    // ********
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        rst_b = 1'b0;
        op = 3'h0;
        pc_val = 16'h0000;
        errors = 0;
        samples_checked = 0;
        test_fill_drain;
        test_overflow;
        test_underflow;
        test_back_to_back;
        conclude;
    end

    // The tests take some 2620 ns; over eleven times that means a hang.
    initial begin
        #30000;
        errors++;
        conclude;
    end
endmodule : testbench
`default_nettype wire
